// ---- inc/sfl_cfg.svh ----
// Purpose: Constants for the single-frequency loop-signaling control block
// Assumes: 50 MHz system clock, millisecond tick as the base interval
// Notes: Times are in milliseconds or minutes; cycle counts derive from them
`ifndef SFL_CFG_SVH
`define SFL_CFG_SVH

// Clock rate and tick unit
`define SFL_CLK_HZ 50000000
`define SFL_TICK_US 1000
`define SFL_MS_PER_S 10'h3E8

// Register byte offsets
`define SFL_CTRL_OFS 8'h00
`define SFL_STAT_OFS 8'h04

// Control field positions
`define SFL_GS_BIT 0
`define SFL_ARD_BIT 1
`define SFL_ML_BIT 2
`define SFL_TL_BIT 3
`define SFL_TO_BIT 4
`define SFL_TO20_BIT 5
`define SFL_CTRL_W 6
`define SFL_CTRL_RST 6'h00

// Status field positions
`define SFL_ST_TX_BIT 0
`define SFL_ST_AUG_BIT 1
`define SFL_ST_CUT_BIT 2
`define SFL_ST_RING_BIT 3
`define SFL_ST_TIPG_BIT 4
`define SFL_ST_LB_BIT 5
`define SFL_ST_GS_LSB 8
`define SFL_ST_LBS_LSB 12

// Intervals in milliseconds
`define SFL_HANG_MS 13'h007D
`define SFL_AUG_MS 13'h0190
`define SFL_BRK_MS 13'h003A
`define SFL_ARM_MS 13'h09C4
`define SFL_EXIT_MS 13'h04B0
`define SFL_DISC_MS 13'h012C
`define SFL_RING_ON_MS 13'h07D0
`define SFL_RING_PER_MS 13'h1770

// Loopback timeouts in minutes
`define SFL_TO_SHORT_MIN 11'h004
`define SFL_TO_LONG_MIN 11'h014
`define SFL_S_PER_MIN 11'h03C

`endif

// ---- inc/sfl_pkg.sv ----
// Purpose: Types shared by the loop-signaling control block
// Assumes: Constants come from sfl_cfg.svh
// Notes: State codes are visible in the status register
package sfl_pkg;

   // Ground-start supervisory states
   typedef enum logic [2:0] {
      SFL_GS_IDLE = 3'h0,
      SFL_GS_COSEIZE = 3'h1,
      SFL_GS_LSEIZE = 3'h2,
      SFL_GS_BUSY = 3'h3,
      SFL_GS_COREL = 3'h4,
      SFL_GS_LDISC = 3'h5
   } sfl_gs_state_e;

   // Tone-activated loopback states
   typedef enum logic [1:0] {
      SFL_LB_OFF = 2'h0,
      SFL_LB_ON = 2'h1,
      SFL_LB_CLR = 2'h2
   } sfl_lb_state_e;

   typedef logic [12:0] sfl_ms_t;

endpackage : sfl_pkg

// ---- hdl/sfl_tick_gen.sv ----
// Purpose: Millisecond and second enable pulses from the system clock
// Assumes: One clock, synchronous active-high reset
// Notes: Each tick is a one-cycle enable, never a derived clock
`include "sfl_cfg.svh"
module sfl_tick_gen #(
   parameter int CYC_PER_MS = 50000
) (
   input wire logic sys_clk,
   input wire logic srst,
   output logic tick_ms,
   output logic tick_s
);
   logic [31:0] cyc_cnt;
   logic [9:0] ms_cnt;
   logic [31:0] next_cyc_cnt;
   logic [9:0] next_ms_cnt;
   logic next_tick_ms;
   logic next_tick_s;

   // Prescaler chain: cycles to milliseconds to seconds
   always_comb begin
      next_cyc_cnt = cyc_cnt + 32'h1;
      next_ms_cnt = ms_cnt;
      next_tick_ms = 1'b0;
      next_tick_s = 1'b0;
      if (cyc_cnt >= 32'(CYC_PER_MS - 1)) begin
         next_cyc_cnt = 32'h0;
         next_tick_ms = 1'b1;
         next_ms_cnt = ms_cnt + 10'h1;
         if (ms_cnt >= `SFL_MS_PER_S - 10'h1) begin
            next_ms_cnt = 10'h0;
            next_tick_s = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cyc_cnt <= 32'h0;
         ms_cnt <= 10'h0;
         tick_ms <= 1'b0;
         tick_s <= 1'b0;
      end else begin
         cyc_cnt <= next_cyc_cnt;
         ms_cnt <= next_ms_cnt;
         tick_ms <= next_tick_ms;
         tick_s <= next_tick_s;
      end
   end
endmodule : sfl_tick_gen

// ---- hdl/sfl_control.sv ----
// Purpose: Supervisory control of a 4-wire SF to 2-wire station-end converter
// Assumes: Detector and loop sense inputs are clean levels synchronous to sys_clk
// Notes: Options sit in an APB control register; state is readable in status
//
// Our own choices: register access over APB and the address map.
`include "sfl_cfg.svh"
module sfl_control
   import sfl_pkg::*;
#(
   parameter int CYC_PER_MS = `SFL_CLK_HZ / 1000000 * `SFL_TICK_US
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_tone_det,
   input wire logic test_tone_det,
   input wire logic loop_current,
   input wire logic ring_ground,
   input wire logic manual_loopback_input,
   output logic tx_tone,
   output logic tx_tone_aug,
   output logic voice_cut,
   output logic ring_drive,
   output logic tip_ground,
   output logic loopback_active
);
   logic tick_ms;
   logic tick_s;
   logic [`SFL_CTRL_W-1:0] ctrl;
   logic [`SFL_CTRL_W-1:0] next_ctrl;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   sfl_gs_state_e gs_state;
   sfl_gs_state_e next_gs_state;
   sfl_lb_state_e lb_state;
   sfl_lb_state_e next_lb_state;
   sfl_ms_t aug_cnt, next_aug_cnt;
   sfl_ms_t hang_cnt, next_hang_cnt;
   sfl_ms_t disc_cnt, next_disc_cnt;
   sfl_ms_t cad_cnt, next_cad_cnt;
   sfl_ms_t brk_cnt, next_brk_cnt;
   sfl_ms_t lb_cnt, next_lb_cnt;
   logic [10:0] to_cnt, next_to_cnt;
   logic next_tx_tone;
   logic next_tx_tone_aug;
   logic next_voice_cut;
   logic next_ring_drive;
   logic next_tip_ground;
   logic next_loopback_active;
   logic manual_lb;
   logic [10:0] to_limit;

   // Millisecond and second enables
   sfl_tick_gen #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_tick (
      .sys_clk(sys_clk),
      .srst(srst),
      .tick_ms(tick_ms),
      .tick_s(tick_s)
   );

   // APB slave: one wait state, then a registered answer
   always_comb begin
      next_ctrl = ctrl;
      next_prdata = 32'h0;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      // Write lands only at the edge that completes the access
      if (psel && penable && pready && pwrite && (paddr == `SFL_CTRL_OFS)) begin
         next_ctrl = pwdata[`SFL_CTRL_W-1:0];
      end
      if (psel && penable && !pready) begin
         next_pready = 1'b1;
         if (paddr == `SFL_CTRL_OFS) begin
            if (!pwrite) begin
               next_prdata = {26'h0, ctrl};
            end
         end else if (paddr == `SFL_STAT_OFS) begin
            if (!pwrite) begin
               next_prdata[`SFL_ST_TX_BIT] = tx_tone;
               next_prdata[`SFL_ST_AUG_BIT] = tx_tone_aug;
               next_prdata[`SFL_ST_CUT_BIT] = voice_cut;
               next_prdata[`SFL_ST_RING_BIT] = ring_drive;
               next_prdata[`SFL_ST_TIPG_BIT] = tip_ground;
               next_prdata[`SFL_ST_LB_BIT] = loopback_active;
               next_prdata[`SFL_ST_GS_LSB +: 3] = gs_state;
               next_prdata[`SFL_ST_LBS_LSB +: 2] = lb_state;
            end
         end else begin
            next_pslverr = 1'b1; // Unmapped address
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ctrl <= `SFL_CTRL_RST;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   assign manual_lb = ctrl[`SFL_ML_BIT] | manual_loopback_input;
   assign to_limit = ctrl[`SFL_TO20_BIT] ? 11'(`SFL_TO_LONG_MIN * `SFL_S_PER_MIN)
                                         : 11'(`SFL_TO_SHORT_MIN * `SFL_S_PER_MIN);

   // Tone loopback sequencing and timeout
   always_comb begin
      next_lb_state = lb_state;
      next_lb_cnt = lb_cnt;
      next_to_cnt = to_cnt;
      if (manual_lb || !ctrl[`SFL_TL_BIT]) begin
         next_lb_state = SFL_LB_OFF;
         next_lb_cnt = 13'h0;
         next_to_cnt = 11'h0;
      end else begin
         unique case (lb_state)
            SFL_LB_OFF: begin
               if (test_tone_det) begin
                  if (tick_ms && lb_cnt < `SFL_ARM_MS) begin
                     next_lb_cnt = lb_cnt + 13'h1;
                  end
               end else begin
                  next_lb_cnt = 13'h0;
                  if (lb_cnt >= `SFL_ARM_MS) begin
                     next_lb_state = SFL_LB_ON;
                     next_to_cnt = 11'h0;
                  end
               end
            end
            SFL_LB_ON: begin
               if (test_tone_det) begin
                  if (tick_ms) begin
                     next_lb_cnt = lb_cnt + 13'h1;
                  end
                  if (lb_cnt >= `SFL_EXIT_MS) begin
                     next_lb_state = SFL_LB_CLR;
                  end
               end else begin
                  next_lb_cnt = 13'h0;
               end
               if (ctrl[`SFL_TO_BIT]) begin
                  if (tick_s) begin
                     next_to_cnt = to_cnt + 11'h1;
                  end
                  if (to_cnt >= to_limit) begin
                     next_lb_state = SFL_LB_OFF;
                     next_lb_cnt = 13'h0;
                  end
               end else begin
                  next_to_cnt = 11'h0;
               end
            end
            SFL_LB_CLR: begin
               next_lb_cnt = 13'h0;
               if (!test_tone_det) begin
                  next_lb_state = SFL_LB_OFF;
               end
            end
         endcase
      end
      next_loopback_active = manual_lb || (next_lb_state == SFL_LB_ON);
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         lb_state <= SFL_LB_OFF;
         lb_cnt <= 13'h0;
         to_cnt <= 11'h0;
         loopback_active <= 1'b0;
      end else begin
         lb_state <= next_lb_state;
         lb_cnt <= next_lb_cnt;
         to_cnt <= next_to_cnt;
         loopback_active <= next_loopback_active;
      end
   end

   // Supervisory tone states, ringing, path cut and tone level
   always_comb begin
      next_gs_state = gs_state;
      next_disc_cnt = 13'h0;
      next_cad_cnt = 13'h0;
      next_brk_cnt = brk_cnt;
      next_tip_ground = 1'b0;
      next_ring_drive = 1'b0;
      next_tx_tone = 1'b0;
      if (!ctrl[`SFL_GS_BIT]) begin
         gs_state_hold: begin
            next_gs_state = SFL_GS_IDLE;
         end
         next_tx_tone = !loop_current;
         next_ring_drive = rx_tone_det && !loop_current;
      end else begin
         unique case (gs_state)
            SFL_GS_IDLE: begin
               next_tx_tone = 1'b1;
               if (ring_ground) begin
                  next_gs_state = SFL_GS_LSEIZE;
               end else if (!rx_tone_det) begin
                  next_gs_state = SFL_GS_COSEIZE;
               end
            end
            SFL_GS_COSEIZE: begin
               next_tx_tone = 1'b1;
               next_tip_ground = 1'b1;
               next_ring_drive = rx_tone_det && !loop_current;
               if (loop_current) begin
                  next_gs_state = SFL_GS_BUSY;
               end
            end
            SFL_GS_LSEIZE: begin
               if (!rx_tone_det) begin
                  next_gs_state = SFL_GS_BUSY;
               end else if (!ring_ground && !loop_current) begin
                  next_gs_state = SFL_GS_IDLE;
               end
            end
            SFL_GS_BUSY: begin
               next_tip_ground = 1'b1;
               // Ring ground still held means acknowledgement, so no tone yet
               next_tx_tone = !loop_current && !ring_ground;
               if (!loop_current && !ring_ground) begin
                  next_disc_cnt = disc_cnt + (tick_ms ? 13'h1 : 13'h0);
               end
               if (rx_tone_det) begin
                  next_gs_state = SFL_GS_COREL;
               end else if (disc_cnt >= `SFL_DISC_MS) begin
                  next_gs_state = SFL_GS_LDISC;
               end
            end
            SFL_GS_COREL: begin
               if (!loop_current && rx_tone_det) begin
                  next_gs_state = SFL_GS_IDLE;
               end
            end
            SFL_GS_LDISC: begin
               next_tx_tone = 1'b1;
               if (rx_tone_det) begin
                  next_gs_state = SFL_GS_IDLE;
               end
            end
            default: begin
               next_gs_state = SFL_GS_IDLE;
            end
         endcase
      end
      // Auto-ringdown rings on loss of far tone with a fixed cadence
      if (ctrl[`SFL_ARD_BIT]) begin
         if (!rx_tone_det && !loop_current) begin
            next_cad_cnt = cad_cnt;
            if (tick_ms) begin
               next_cad_cnt = (cad_cnt >= `SFL_RING_PER_MS - 13'h1) ? 13'h0 : cad_cnt + 13'h1;
            end
         end
         next_ring_drive = !rx_tone_det && !loop_current && (cad_cnt < `SFL_RING_ON_MS);
      end
      // Loopback echo with minimum break stretching
      if (rx_tone_det) begin
         next_brk_cnt = `SFL_BRK_MS;
      end else if (tick_ms && brk_cnt != 13'h0) begin
         next_brk_cnt = brk_cnt - 13'h1;
      end
      if (loopback_active) begin
         next_tx_tone = rx_tone_det || (brk_cnt != 13'h0);
         next_ring_drive = 1'b0;
         next_tip_ground = 1'b0;
      end
      // Augmented level at each tone onset
      next_aug_cnt = aug_cnt;
      if (next_tx_tone && !tx_tone) begin
         next_aug_cnt = `SFL_AUG_MS;
      end else if (tick_ms && aug_cnt != 13'h0) begin
         next_aug_cnt = aug_cnt - 13'h1;
      end
      next_tx_tone_aug = next_tx_tone && (next_aug_cnt != 13'h0);
      // Voice path cut with hangover after tone stops
      next_hang_cnt = hang_cnt;
      if (next_tx_tone) begin
         next_hang_cnt = `SFL_HANG_MS;
      end else if (tick_ms && hang_cnt != 13'h0) begin
         next_hang_cnt = hang_cnt - 13'h1;
      end
      next_voice_cut = !loop_current || next_tx_tone || (hang_cnt != 13'h0);
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         gs_state <= SFL_GS_IDLE;
         disc_cnt <= 13'h0;
         cad_cnt <= 13'h0;
         brk_cnt <= 13'h0;
         aug_cnt <= 13'h0;
         hang_cnt <= 13'h0;
         tx_tone <= 1'b0;
         tx_tone_aug <= 1'b0;
         voice_cut <= 1'b1;
         ring_drive <= 1'b0;
         tip_ground <= 1'b0;
      end else begin
         gs_state <= next_gs_state;
         disc_cnt <= next_disc_cnt;
         cad_cnt <= next_cad_cnt;
         brk_cnt <= next_brk_cnt;
         aug_cnt <= next_aug_cnt;
         hang_cnt <= next_hang_cnt;
         tx_tone <= next_tx_tone;
         tx_tone_aug <= next_tx_tone_aug;
         voice_cut <= next_voice_cut;
         ring_drive <= next_ring_drive;
         tip_ground <= next_tip_ground;
      end
   end
endmodule : sfl_control

// ---- tb/sfl_control_checker.sv ----
// Purpose: Port assertions for the loop-signaling control block
// Assumes: One clock, srst synchronous active high
// Notes: Watches only the ports that the checks tie together
module sfl_control_checker #(
   parameter int CYC_PER_MS = 50
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic loop_current,
   input wire logic manual_loopback_input,
   input wire logic tx_tone,
   input wire logic tx_tone_aug,
   input wire logic voice_cut,
   input wire logic loopback_active
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HANG = 124 * CYC_PER_MS;
   localparam int AUGX = 402 * CYC_PER_MS;
   int hang_cnt;
   int aug_cnt;
   int next_hang_cnt;
   int next_aug_cnt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Cycles since tone out stopped, and length of the augmented burst
   always_comb begin
      next_hang_cnt = (hang_cnt < HANG) ? hang_cnt + 1 : hang_cnt;
      next_aug_cnt = tx_tone_aug ? aug_cnt + 1 : 0;
      if (tx_tone) begin
         next_hang_cnt = 0;
      end
      if (srst) begin
         next_hang_cnt = HANG;
         next_aug_cnt = 0;
      end
   end
   // Register the counters
   always_ff @(posedge sys_clk) begin
      hang_cnt <= next_hang_cnt;
      aug_cnt <= next_aug_cnt;
   end
   a_pready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   a_slverr_map: assert property (pready |-> pslverr == (paddr != 8'h00 && paddr != 8'h04))
      else $error("pslverr wrong");
   a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero");
   a_cut_on_open: assert property ($fell(loop_current) |-> ##[1:2] voice_cut)
      else $error("no cut on open");
   a_cut_with_tone: assert property (tx_tone |-> voice_cut)
      else $error("no cut with tone");
   a_cut_hang: assert property (!tx_tone && hang_cnt < HANG |-> voice_cut)
      else $error("cut ended early");
   a_aug_on_rise: assert property ($rose(tx_tone) |-> tx_tone_aug)
      else $error("no burst");
   a_aug_bound: assert property (aug_cnt <= AUGX)
      else $error("burst too long");
   a_lb_manual: assert property ($rose(manual_loopback_input) |-> ##[1:3] loopback_active)
      else $error("no manual loopback");
   c_lb: cover property ($rose(loopback_active));
   c_err: cover property (pready && pslverr);
   c_hang: cover property ($fell(voice_cut));
endmodule : sfl_control_checker

// ---- tb/sfl_line_model.sv ----
// Purpose: Far side: facility tone detectors and the station loop
// Assumes: Levels change just after a rising edge
// Notes: Station answers ringing after answer_ms unless that is 0
module sfl_line_model #(
   parameter int CYC_PER_MS = 50
) (
   input wire logic sys_clk,
   input wire logic ring_drive,
   output logic rx_tone_det,
   output logic test_tone_det,
   output logic loop_current,
   output logic ring_ground
);
   timeunit 1ns;
   timeprecision 1ns;
   int answer_ms = 0;
   int ring_cyc = 0;
   logic [3:0] lvl = 4'h0;
   logic answered = 1'b0;
   // Line levels; an answering station closes the loop on top of them
   assign {loop_current, rx_tone_det, test_tone_det, ring_ground} = lvl | {answered, 3'h0};
   // Levels {loop, rx tone, test tone, ring ground} from the next edge
   task drive(input logic [3:0] v);
      @(posedge sys_clk);
      lvl <= v;
   endtask : drive
   // Station stays off hook from answer_ms of ringing until answer_ms is cleared
   always @(posedge sys_clk) begin
      ring_cyc <= ring_drive ? ring_cyc + 1 : 0;
      answered <= (answer_ms != 0) && (answered || (ring_cyc == answer_ms * CYC_PER_MS));
   end
endmodule : sfl_line_model

// ---- tb/tb_sf_loop_signaling_control.sv ----
// Purpose: Self-checking bench for the loop-signaling control block
// Assumes: Millisecond prescale shortened to 8 cycles
// Notes: Minute timeouts of tone loopback are not run
module tb_sf_loop_signaling_control;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int CPM = 8;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic manual_loopback_input = 1'b0;
   logic [31:0] prdata, rd, w;
   logic pready, pslverr, er, rx_tone_det, test_tone_det, loop_current, ring_ground;
   logic tx_tone, tx_tone_aug, voice_cut, ring_drive, tip_ground, loopback_active;
   int n_errors = 0;
   int checked = 0;
   int seed = 19;
   // Ground-start walk: {loop, rx, test, ring ground}, wait in ms, tone out
   logic [3:0] gs_line [10] = '{4'h4, 4'h5, 4'h1, 4'h8, 4'h0, 4'h4, 4'h0, 4'h8, 4'hC, 4'h4};
   int gs_ms [10] = '{5, 2, 2, 2, 320, 5, 3, 2, 5, 3};
   logic gs_tx [10] = '{1, 0, 0, 0, 1, 1, 1, 0, 0, 1};
   logic gs_tip [10] = '{0, 0, 1, 1, 0, 0, 1, 1, 0, 0};
   sfl_control #(.CYC_PER_MS(CPM)) dut (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rx_tone_det, .test_tone_det, .loop_current,
      .ring_ground, .manual_loopback_input, .tx_tone, .tx_tone_aug, .voice_cut, .ring_drive,
      .tip_ground, .loopback_active);
   sfl_line_model #(.CYC_PER_MS(CPM)) far (.sys_clk, .ring_drive, .rx_tone_det,
      .test_tone_det, .loop_current, .ring_ground);
   // Clock
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   // Loop-start tone out: on while the loop is open
   function automatic logic ls_tx(input logic closed);
      return !closed;
   endfunction : ls_tx
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk
   task tally_and_finish;
      $display("checked %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // One APB transfer, entered just after a rising edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a hang
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle cycle so a following call never reassigns psel in this step
      @(posedge sys_clk);
   endtask : apb
   task ms(input int n);
      repeat (n * CPM) @(posedge sys_clk);
   endtask : ms
   // Watchdog
   initial begin
      repeat (100000) @(posedge sys_clk);
      n_errors++;
      tally_and_finish;
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl rst", rd, 32'h0);
      repeat (3) begin
         w = $random(seed);
         apb(1'b1, 8'h00, w);
         apb(1'b0, 8'h00, 32'h0);
         chk("ctrl", rd, w & 32'h3F);
      end
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h04, w);
      chk("stat wr", er, 32'h0);
      apb(1'b1, 8'h08, w);
      chk("bad wr", er, 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      chk("bad rd", {rd[30:0], er}, 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl kept", rd, 32'h0);
      $display("test regs done");
      ms(1);
      chk("idle tx", tx_tone, ls_tx(1'b0));
      chk("idle cut", voice_cut, 1);
      ms(420);
      apb(1'b0, 8'h04, 32'h0);
      chk("status", rd & 32'h3F, 32'h5);
      far.drive(4'h8);
      ms(1);
      chk("offhk tx", tx_tone, ls_tx(1'b1));
      ms(115);
      chk("hang cut", voice_cut, 1);
      ms(15);
      chk("hang end", voice_cut, 0);
      // Two dial pulses
      repeat (2) begin
         far.drive(4'h0);
         ms(1);
         chk("brk cut", voice_cut, 1);
         ms(30);
         chk("brk tx", tx_tone, ls_tx(1'b0));
         far.drive(4'h8);
         ms(90);
         chk("make tx", tx_tone, ls_tx(1'b1));
      end
      $display("test loop start done");
      // Ringing, answered by the station after 20 ms
      far.answer_ms = 20;
      far.drive(4'h4);
      ms(10);
      chk("ring", {ring_drive, tx_tone}, 2'b11);
      ms(20);
      far.drive(4'h8);
      ms(5);
      chk("talk", {ring_drive, tx_tone}, 2'b00);
      far.answer_ms = 0;
      $display("test ringing done");
      // Idle line first so ground start begins in its idle state
      far.drive(4'h4);
      ms(1);
      apb(1'b1, 8'h00, 32'h1);
      for (int i = 0; i < 10; i++) begin
         far.drive(gs_line[i]);
         ms(gs_ms[i]);
         chk("gs tx tip", {tip_ground, tx_tone}, {gs_tip[i], gs_tx[i]});
      end
      $display("test ground start done");
      // Tone loopback: short arm tone refused, full one enters on removal
      apb(1'b1, 8'h00, 32'h8);
      far.drive(4'hA);
      ms(2400);
      far.drive(4'h8);
      ms(5);
      chk("short arm", loopback_active, 0);
      far.drive(4'hA);
      ms(2510);
      chk("arm held", loopback_active, 0);
      far.drive(4'h8);
      ms(5);
      chk("lb on", loopback_active, 1);
      repeat (2) begin
         far.drive(4'hC);
         ms(2);
         chk("echo aug", {tx_tone, tx_tone_aug}, 2'b11);
         ms(405);
         chk("echo norm", {tx_tone, tx_tone_aug}, 2'b10);
         far.drive(4'h8);
         ms(30);
         chk("min brk", tx_tone, 1);
         ms(40);
         chk("brk end", tx_tone, 0);
      end
      far.drive(4'hA);
      ms(1100);
      chk("2nd short", loopback_active, 1);
      ms(110);
      chk("lb off", loopback_active, 0);
      $display("test tone loopback done");
      manual_loopback_input <= 1'b1;
      far.drive(4'hA);
      ms(1300);
      chk("man lb", loopback_active, 1);
      manual_loopback_input <= 1'b0;
      far.drive(4'h8);
      ms(2);
      chk("man off", loopback_active, 0);
      apb(1'b1, 8'h00, 32'h4);
      ms(1);
      chk("ml bit", loopback_active, 1);
      $display("test manual loopback done");
      tally_and_finish;
   end
endmodule : tb_sf_loop_signaling_control
bind sfl_control sfl_control_checker #(.CYC_PER_MS(CYC_PER_MS)) chk_i (.sys_clk(sys_clk),
   .srst(srst), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .loop_current(loop_current),
   .manual_loopback_input(manual_loopback_input), .tx_tone(tx_tone),
   .tx_tone_aug(tx_tone_aug), .voice_cut(voice_cut), .loopback_active(loopback_active));
